// [rtl/e1s_status_top.sv]
// Purpose: status and information registers of an E1 transceiver on the parallel port
// Assumes: host strobes are one cycle and synchronous to I_CORE_CLK
// Notes: framer, elastic stores and line interface sit outside; they feed event inputs
`timescale 1ns/10ps
`default_nettype none
`include "e1s_defs.svh"
module e1s_status_top #(
  parameter int LIF_RECOVER_CYC = `E1S_LIF_RECOVER_MS * 1000 * `E1S_CORE_CLK_MHZ
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  input wire e1s_pkg::e1s_addr_t I_ADDR,
  input wire e1s_pkg::e1s_byte_t I_WDATA,
  input wire e1s_pkg::e1s_byte_t I_ALARM_ONE_SET,
  input wire e1s_pkg::e1s_byte_t I_EVENT_TWO_SET,
  input wire logic I_TX_STORE_FULL,
  input wire logic I_TX_STORE_EMPTY,
  input wire logic I_JITTER_FIFO_LIMIT,
  input wire logic I_RX_STORE_FULL,
  input wire logic I_RX_STORE_EMPTY,
  input wire logic I_CRC_RESYNC,
  input wire logic I_FRAME_ALIGN_RESYNC,
  input wire logic I_SIG_MF_RESYNC,
  input wire logic I_CRC_SEARCH_TIMEOUT,
  input wire logic I_CRC_SYNC_OK,
  input wire logic I_FRAME_ALIGN_SEARCH,
  input wire logic I_SIG_MF_SEARCH,
  input wire logic I_CRC_MF_SEARCH,
  output logic [7:0] O_RDATA,
  output logic O_RD_VALID,
  output logic O_IRQ_OUT_ONE,
  output logic O_IRQ_OUT_TWO,
  output logic O_LINE_IF_RST,
  output logic O_LINE_IF_BUSY,
  output logic O_ES_DEPTH_RST,
  output logic O_CRC_MODE_EN
);
  import e1s_pkg::*;
  localparam int LIF_CW = $clog2(LIF_RECOVER_CYC + 1);
  localparam logic [LIF_CW-1:0] LIF_LAST = LIF_CW'(LIF_RECOVER_CYC - 1);

  function automatic logic f_hit(input e1s_addr_t addr, input e1s_addr_t target);
    f_hit = (addr == target);
  endfunction

  e1s_flag_if sr1_if ();
  e1s_flag_if sr2_if ();
  e1s_flag_if rir_if ();

  e1s_byte_t irq_mask_one_ff;
  e1s_byte_t irq_mask_two_ff;
  e1s_byte_t ccr1_ff;
  e1s_byte_t ccr3_ff;
  e1s_byte_t ccr3_d_ff;
  e1s_byte_t rdata_ff;
  e1s_byte_t nxt_rdata;
  e1s_byte_t rir_set;
  logic [7:0] sync_search_status;
  logic rd_valid_ff;
  logic irq1_ff;
  logic irq2_ff;
  logic line_rst_ff;
  logic lif_busy_ff;
  logic es_rst_ff;
  logic crc_en_ff;
  logic line_if_reset_bit_rise;
  logic esr_fall;
  e1s_lif_e lif_state_ff;
  e1s_lif_e nxt_lif_state;
  logic [LIF_CW-1:0] lif_cnt_ff;

  // receive information events, each on its own bit
  always_comb begin
    rir_set = 8'h00;
    rir_set[`E1S_RIR_TX_FULL] = I_TX_STORE_FULL;
    rir_set[`E1S_RIR_TX_EMPTY] = I_TX_STORE_EMPTY;
    rir_set[`E1S_RIR_JIT_LIMIT] = I_JITTER_FIFO_LIMIT;
    rir_set[`E1S_RIR_RX_FULL] = I_RX_STORE_FULL;
    rir_set[`E1S_RIR_RX_EMPTY] = I_RX_STORE_EMPTY;
    rir_set[`E1S_RIR_CRC_RESYNC] = I_CRC_RESYNC;
    rir_set[`E1S_RIR_FAS_RESYNC] = I_FRAME_ALIGN_RESYNC;
    rir_set[`E1S_RIR_CAS_RESYNC] = I_SIG_MF_RESYNC;
  end

  // alarm inputs are levels, so a persisting alarm keeps its bit set through a clear
  assign sr1_if.set = I_ALARM_ONE_SET;
  assign sr1_if.wr = I_WR_STB && f_hit(I_ADDR, `E1S_ADDR_SR1);
  assign sr1_if.wmask = I_WDATA;
  assign sr2_if.set = I_EVENT_TWO_SET;
  assign sr2_if.wr = I_WR_STB && f_hit(I_ADDR, `E1S_ADDR_SR2);
  assign sr2_if.wmask = I_WDATA;
  assign rir_if.set = rir_set;
  assign rir_if.wr = I_WR_STB && f_hit(I_ADDR, `E1S_ADDR_RIR);
  assign rir_if.wmask = I_WDATA;

  e1s_latch_reg u_sr1 (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .flg(sr1_if.owner)
  );
  e1s_latch_reg u_sr2 (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .flg(sr2_if.owner)
  );
  e1s_latch_reg u_rir (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .flg(rir_if.owner)
  );

  e1s_sync_cnt u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_timeout(I_CRC_SEARCH_TIMEOUT),
    .i_sync_ok(I_CRC_SYNC_OK),
    .i_mode_en(ccr1_ff[`E1S_CCR1_CRC_EN]),
    .i_fas_search(I_FRAME_ALIGN_SEARCH),
    .i_cas_search(I_SIG_MF_SEARCH),
    .i_crc_search(I_CRC_MF_SEARCH),
    .o_ssr(sync_search_status)
  );

  // control registers; contents are defined at reset even though software must rewrite them
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      irq_mask_one_ff <= `E1S_RST_BYTE;
      irq_mask_two_ff <= `E1S_RST_BYTE;
      ccr1_ff <= `E1S_RST_BYTE;
      ccr3_ff <= `E1S_RST_BYTE;
    end else if (I_WR_STB) begin
      if (f_hit(I_ADDR, `E1S_ADDR_IRQ_MASK_ONE)) begin
        irq_mask_one_ff <= I_WDATA;
      end
      if (f_hit(I_ADDR, `E1S_ADDR_IRQ_MASK_TWO)) begin
        irq_mask_two_ff <= I_WDATA;
      end
      if (f_hit(I_ADDR, `E1S_ADDR_CCR1)) begin
        ccr1_ff <= I_WDATA;
      end
      if (f_hit(I_ADDR, `E1S_ADDR_CCR3)) begin
        ccr3_ff <= I_WDATA;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      crc_en_ff <= 1'b0;
    end else begin
      crc_en_ff <= ccr1_ff[`E1S_CCR1_CRC_EN];
    end
  end

  // read port; writes to the synchronizer status address are ignored
  always_comb begin
    nxt_rdata = 8'h00;
    case (I_ADDR)
      `E1S_ADDR_SR1: nxt_rdata = sr1_if.view;
      `E1S_ADDR_SR2: nxt_rdata = sr2_if.view;
      `E1S_ADDR_RIR: nxt_rdata = rir_if.view;
      `E1S_ADDR_SSR: nxt_rdata = sync_search_status;
      `E1S_ADDR_IRQ_MASK_ONE: nxt_rdata = irq_mask_one_ff;
      `E1S_ADDR_IRQ_MASK_TWO: nxt_rdata = irq_mask_two_ff;
      `E1S_ADDR_CCR1: nxt_rdata = ccr1_ff;
      `E1S_ADDR_CCR3: nxt_rdata = ccr3_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rdata_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= I_RD_STB;
      if (I_RD_STB) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // interrupts follow the latches, not the readable copies
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      irq1_ff <= 1'b0;
      irq2_ff <= 1'b0;
    end else begin
      irq1_ff <= |(sr1_if.latch & irq_mask_one_ff);
      irq2_ff <= |(sr2_if.latch & irq_mask_two_ff);
    end
  end

  // edges of the two reset bits of the third control register
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ccr3_d_ff <= `E1S_RST_BYTE;
    end else begin
      ccr3_d_ff <= ccr3_ff;
    end
  end
  assign line_if_reset_bit_rise = ccr3_ff[`E1S_CCR3_LINE_IF_RESET_BIT] && !ccr3_d_ff[`E1S_CCR3_LINE_IF_RESET_BIT];
  assign esr_fall = !ccr3_ff[`E1S_CCR3_ESR] && ccr3_d_ff[`E1S_CCR3_ESR];

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      es_rst_ff <= 1'b0;
    end else begin
      es_rst_ff <= esr_fall;
    end
  end

  // line interface reset and recovery; a new rising edge restarts the wait
  always_comb begin
    nxt_lif_state = lif_state_ff;
    case (lif_state_ff)
      LIF_IDLE: begin
        if (line_if_reset_bit_rise) begin
          nxt_lif_state = LIF_RESET;
        end
      end
      LIF_RESET: begin
        nxt_lif_state = LIF_RECOVER;
      end
      LIF_RECOVER: begin
        if (line_if_reset_bit_rise) begin
          nxt_lif_state = LIF_RESET;
        end else if (lif_cnt_ff == LIF_LAST) begin
          nxt_lif_state = LIF_IDLE;
        end
      end
      default: nxt_lif_state = LIF_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      lif_state_ff <= LIF_IDLE;
      lif_cnt_ff <= '0;
    end else begin
      lif_state_ff <= nxt_lif_state;
      if (nxt_lif_state == LIF_RECOVER && lif_state_ff == LIF_RECOVER) begin
        lif_cnt_ff <= LIF_CW'(lif_cnt_ff + 1'b1);
      end else begin
        lif_cnt_ff <= '0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      line_rst_ff <= 1'b0;
      lif_busy_ff <= 1'b0;
    end else begin
      line_rst_ff <= (nxt_lif_state == LIF_RESET);
      lif_busy_ff <= (nxt_lif_state != LIF_IDLE);
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_RD_VALID = rd_valid_ff;
  assign O_IRQ_OUT_ONE = irq1_ff;
  assign O_IRQ_OUT_TWO = irq2_ff;
  assign O_LINE_IF_RST = line_rst_ff;
  assign O_LINE_IF_BUSY = lif_busy_ff;
  assign O_ES_DEPTH_RST = es_rst_ff;
  assign O_CRC_MODE_EN = crc_en_ff;

  AST_IRQ_ONE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (|(sr1_if.latch & irq_mask_one_ff)) |=> O_IRQ_OUT_ONE)
    else $error("interrupt one missing for enabled bit");
  AST_IRQ_TWO_MASKED: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    ((sr2_if.latch & irq_mask_two_ff) == 8'h00) |=> !O_IRQ_OUT_TWO)
    else $error("interrupt two raised with no enabled bit");
  AST_ES_PULSE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    esr_fall |=> O_ES_DEPTH_RST ##1 !O_ES_DEPTH_RST)
    else $error("store depth reset pulse wrong");
  AST_LIF_START: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (line_if_reset_bit_rise && lif_state_ff == LIF_IDLE) |=> O_LINE_IF_RST ##1 (!O_LINE_IF_RST && O_LINE_IF_BUSY))
    else $error("line reset not started");
  AST_LIF_DONE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (lif_state_ff == LIF_RECOVER && lif_cnt_ff == LIF_LAST && !line_if_reset_bit_rise) |=> !O_LINE_IF_BUSY)
    else $error("line recovery did not end on time");
  AST_RD_SSR: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (I_RD_STB && f_hit(I_ADDR, `E1S_ADDR_SSR)) |=> (O_RD_VALID && O_RDATA == $past(sync_search_status)))
    else $error("synchronizer status read wrong");
endmodule // e1s_status_top
`default_nettype wire

// [rtl/e1s_defs.svh]
// Purpose: register offsets, field positions, reset values and timing for the status block
// Assumes: 8-bit parallel control port, one 200 MHz core clock
// Notes: included by bare name
`ifndef E1S_DEFS_SVH
`define E1S_DEFS_SVH
`define E1S_ADDR_SR1 8'h06
`define E1S_ADDR_SR2 8'h07
`define E1S_ADDR_RIR 8'h08
`define E1S_ADDR_CCR1 8'h10
`define E1S_ADDR_IRQ_MASK_ONE 8'h16
`define E1S_ADDR_IRQ_MASK_TWO 8'h17
`define E1S_ADDR_CCR3 8'h1b
`define E1S_ADDR_SSR 8'h1e
`define E1S_RIR_TX_FULL 7
`define E1S_RIR_TX_EMPTY 6
`define E1S_RIR_JIT_LIMIT 5
`define E1S_RIR_RX_FULL 4
`define E1S_RIR_RX_EMPTY 3
`define E1S_RIR_CRC_RESYNC 2
`define E1S_RIR_FAS_RESYNC 1
`define E1S_RIR_CAS_RESYNC 0
`define E1S_CCR1_CRC_EN 0
`define E1S_CCR3_ESR 4
`define E1S_CCR3_LINE_IF_RESET_BIT 3
`define E1S_RST_BYTE 8'h00
`define E1S_RST_CSC 6'h00
`define E1S_CSC_W 6
`define E1S_LIF_RECOVER_MS 40
`define E1S_CORE_CLK_MHZ 200
`endif

// [rtl/e1s_pkg.sv]
// Purpose: shared types of the status and information block
// Assumes: nothing beyond the defs header
// Notes: constants live in e1s_defs.svh
package e1s_pkg;
  typedef logic [7:0] e1s_byte_t;
  typedef logic [7:0] e1s_addr_t;
  typedef logic [5:0] e1s_csc_t;
  typedef enum logic [1:0] {LIF_IDLE, LIF_RESET, LIF_RECOVER} e1s_lif_e;
endpackage

// [rtl/e1s_flag_if.sv]
// Purpose: carrier between the top and one latched flag register
// Assumes: all signals on the core clock
// Notes: set is a per-bit event or condition level
`timescale 1ns/10ps
`default_nettype none
interface e1s_flag_if;
  logic [7:0] set;
  logic wr;
  logic [7:0] wmask;
  logic [7:0] latch;
  logic [7:0] view;
  modport owner (input set, input wr, input wmask, output latch, output view);
  modport user (output set, output wr, output wmask, input latch, input view);
endinterface
`default_nettype wire

// [rtl/e1s_latch_reg.sv]
// Purpose: one latched status byte with its masked readable copy
// Assumes: write strobe is one cycle per host write
// Notes: set wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module e1s_latch_reg (
  input wire logic i_clk,
  input wire logic i_rst_n,
  e1s_flag_if.owner flg
);
  import e1s_pkg::*;
  logic [7:0] latch_ff;
  logic [7:0] view_ff;
  logic [7:0] clr_mask;
  logic [7:0] now_val;
  assign clr_mask = flg.wr ? flg.wmask : 8'h00;
  // a bit set this cycle is part of the current value, so it is never lost
  assign now_val = latch_ff | flg.set;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      latch_ff <= 8'h00;
    end else begin
      latch_ff <= (latch_ff & ~clr_mask) | flg.set;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      view_ff <= 8'h00;
    end else begin
      view_ff <= (view_ff & ~clr_mask) | (now_val & clr_mask);
    end
  end
  assign flg.latch = latch_ff;
  assign flg.view = view_ff;
  AST_LATCH_STICKS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (flg.set != 8'h00) |=> ((latch_ff & $past(flg.set)) == $past(flg.set)))
    else $error("latched bit did not set");
  AST_LATCH_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!flg.wr && flg.set == 8'h00) |=> (latch_ff == $past(latch_ff)))
    else $error("latched bit changed without event or clear");
  AST_WR_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (flg.wr && flg.set == 8'h00) |=> ((latch_ff & $past(flg.wmask)) == 8'h00))
    else $error("masked bit not cleared by write");
  AST_VIEW_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    flg.wr |=> ((view_ff & $past(flg.wmask)) == ($past(now_val) & $past(flg.wmask)))
      && ((view_ff & ~$past(flg.wmask)) == ($past(view_ff) & ~$past(flg.wmask))))
    else $error("readable copy not loaded or held per mask");
endmodule // e1s_latch_reg
`default_nettype wire

// [rtl/e1s_sync_cnt.sv]
// Purpose: crc4 sync counter and the live synchronizer status byte
// Assumes: timeout is a one-cycle pulse per expired 8 ms search
// Notes: counter bit 1 is kept but never shown
`timescale 1ns/10ps
`default_nettype none
`include "e1s_defs.svh"
module e1s_sync_cnt (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_timeout,
  input wire logic i_sync_ok,
  input wire logic i_mode_en,
  input wire logic i_fas_search,
  input wire logic i_cas_search,
  input wire logic i_crc_search,
  output logic [7:0] o_ssr
);
  import e1s_pkg::*;
  e1s_csc_t cnt_ff;
  e1s_csc_t nxt_cnt;
  logic [7:0] ssr_ff;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!i_mode_en || i_sync_ok) begin
      nxt_cnt = `E1S_RST_CSC;
    end else if (i_timeout) begin
      nxt_cnt = e1s_csc_t'(cnt_ff + 6'h01);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= `E1S_RST_CSC;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // unlatched: rebuilt every cycle from live state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ssr_ff <= 8'h00;
    end else begin
      ssr_ff <= {nxt_cnt[5:2], nxt_cnt[0], i_fas_search, i_cas_search, i_crc_search};
    end
  end
  assign o_ssr = ssr_ff;
  AST_CSC_INC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mode_en && !i_sync_ok && i_timeout) |=> (cnt_ff == e1s_csc_t'($past(cnt_ff) + 6'h01)))
    else $error("sync counter did not step or wrap");
  AST_CSC_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_mode_en || i_sync_ok) |=> (cnt_ff == 6'h00))
    else $error("sync counter not cleared");
  AST_SSR_MAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> (ssr_ff == {cnt_ff[5:2], cnt_ff[0], $past(i_fas_search),
      $past(i_cas_search), $past(i_crc_search)}))
    else $error("status byte does not mirror counter and search state");
endmodule // e1s_sync_cnt
`default_nettype wire

// [bench/e1s_host_model.sv]
// Purpose: host on the parallel control port, one-cycle strobes
// Assumes: strobes launched by non-blocking assignment at the rising edge
// Notes: read data taken once the valid pulse is seen
`timescale 1ns/10ps
`default_nettype none
module e1s_host_model (
  input wire logic i_clk,
  input wire logic i_rd_valid,
  input wire e1s_pkg::e1s_byte_t i_rdata,
  output var logic o_wr_stb,
  output var logic o_rd_stb,
  output var e1s_pkg::e1s_addr_t o_addr,
  output var e1s_pkg::e1s_byte_t o_wdata
);
  import e1s_pkg::*;
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic write_reg(input e1s_addr_t a, input e1s_byte_t d);
    @(posedge i_clk);
    o_wr_stb <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
  endtask
  task automatic read_reg(input e1s_addr_t a, output e1s_byte_t d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    o_rd_stb <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        d = i_rdata;
        ok = 1'b1;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask
  // mask write, read, masked write-back: events race the port, so clear twice
  task automatic poll(input e1s_addr_t a, input e1s_byte_t m, output e1s_byte_t v,
                      output logic ok);
    write_reg(a, m);
    read_reg(a, v, ok);
    write_reg(a, v & m);
  endtask
endmodule // e1s_host_model
`default_nettype wire

// [bench/e1s_status_top_tb_top.sv]
// Purpose: self-checking bench of the status and information block
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes: line recovery shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
`include "e1s_defs.svh"
module e1s_status_top_tb_top;
  import e1s_pkg::*;
  localparam int LIF_CYC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, rdv, irq1, irq2, lrst, busy, elastic_store_reset_bit, mode;
  e1s_addr_t addr;
  e1s_byte_t wdata, rdata, a1, e2, receive_info_flags, v;
  logic tmo, sok;
  logic [2:0] srch;
  int mismatches = 0;
  int samples_checked = 0;
  int rs, bz, es;
  e1s_addr_t ctl [4] = '{`E1S_ADDR_CCR1, `E1S_ADDR_CCR3, `E1S_ADDR_IRQ_MASK_ONE, `E1S_ADDR_IRQ_MASK_TWO};
  e1s_addr_t sts [3] = '{`E1S_ADDR_SR1, `E1S_ADDR_SR2, `E1S_ADDR_RIR};
  always #2.5 clk = ~clk;
  e1s_host_model host (.i_clk(clk), .i_rd_valid(rdv), .i_rdata(rdata), .o_wr_stb(wr),
    .o_rd_stb(rd), .o_addr(addr), .o_wdata(wdata));
  e1s_status_top #(.LIF_RECOVER_CYC(LIF_CYC)) uut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_WR_STB(wr), .I_RD_STB(rd), .I_ADDR(addr), .I_WDATA(wdata), .I_ALARM_ONE_SET(a1),
    .I_EVENT_TWO_SET(e2), .I_TX_STORE_FULL(receive_info_flags[7]), .I_TX_STORE_EMPTY(receive_info_flags[6]),
    .I_JITTER_FIFO_LIMIT(receive_info_flags[5]), .I_RX_STORE_FULL(receive_info_flags[4]), .I_RX_STORE_EMPTY(receive_info_flags[3]),
    .I_CRC_RESYNC(receive_info_flags[2]), .I_FRAME_ALIGN_RESYNC(receive_info_flags[1]), .I_SIG_MF_RESYNC(receive_info_flags[0]),
    .I_CRC_SEARCH_TIMEOUT(tmo), .I_CRC_SYNC_OK(sok), .I_FRAME_ALIGN_SEARCH(srch[2]),
    .I_SIG_MF_SEARCH(srch[1]), .I_CRC_MF_SEARCH(srch[0]), .O_RDATA(rdata),
    .O_RD_VALID(rdv), .O_IRQ_OUT_ONE(irq1), .O_IRQ_OUT_TWO(irq2), .O_LINE_IF_RST(lrst),
    .O_LINE_IF_BUSY(busy), .O_ES_DEPTH_RST(elastic_store_reset_bit), .O_CRC_MODE_EN(mode));
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input e1s_addr_t a, input e1s_byte_t exp);
    logic ok;
    host.read_reg(a, v, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t read gave no answer", $time);
      end_of_test();
    end
    check(v, exp);
  endtask
  task automatic poll_chk(input e1s_addr_t a, input e1s_byte_t m, input e1s_byte_t exp);
    logic ok;
    host.poll(a, m, v, ok);
    check({7'h00, ok}, 8'h01);
    check(v, exp);
    if (ok !== 1'b1) begin
      end_of_test();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int sel, input e1s_byte_t b);
    @(posedge clk);
    case (sel)
      0: a1 <= b;
      1: e2 <= b;
      2: receive_info_flags <= b;
      3: tmo <= 1'b1;
      default: sok <= 1'b1;
    endcase
    @(posedge clk);
    a1 <= 8'h00;
    e2 <= 8'h00;
    receive_info_flags <= 8'h00;
    tmo <= 1'b0;
    sok <= 1'b0;
  endtask
  task automatic tpulse(input int n);
    repeat (n) pulse(3, 8'h00);
    idle(2);
  endtask
  task automatic watch(input int n);
    rs = 0;
    bz = 0;
    es = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      rs += (lrst === 1'b1);
      bz += (busy === 1'b1);
      es += (elastic_store_reset_bit === 1'b1);
    end
  endtask
  function automatic e1s_byte_t exp_ssr(input logic [5:0] c);
    return {c[5:2], c[0], 3'b101};
  endfunction
  initial begin
    #400000;
    mismatches++;
    $display("[FAIL] %0t run did not finish", $time);
    end_of_test();
  end
  initial begin
    {a1, e2, receive_info_flags, tmo, sok, srch} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    check({2'b00, irq1, irq2, lrst, busy, elastic_store_reset_bit, mode}, 8'h00);
    srch <= 3'b101;
    rd_chk(`E1S_ADDR_SSR, 8'h05);
    srch <= 3'b010;
    rd_chk(`E1S_ADDR_SSR, 8'h02);
    srch <= 3'b101;
    foreach (ctl[i]) host.write_reg(ctl[i], 8'h00);
    foreach (ctl[i]) rd_chk(ctl[i], 8'h00);
    foreach (sts[i]) poll_chk(sts[i], 8'hff, 8'h00);
    host.write_reg(`E1S_ADDR_CCR3, 8'h08);
    watch(LIF_CYC + 10);
    check(rs[7:0], 8'h01);
    check(bz[7:0], 8'(LIF_CYC + 1));
    host.write_reg(`E1S_ADDR_CCR3, 8'h08);
    watch(6);
    check(rs[7:0], 8'h00);
    host.write_reg(`E1S_ADDR_CCR3, 8'h10);
    watch(6);
    check(es[7:0], 8'h00);
    host.write_reg(`E1S_ADDR_CCR3, 8'h00);
    watch(6);
    check(es[7:0], 8'h01);
    host.write_reg(`E1S_ADDR_CCR1, 8'h01);
    tpulse(5);
    check({7'h00, mode}, 8'h01);
    rd_chk(`E1S_ADDR_SSR, exp_ssr(6'd5));
    tpulse(59);
    rd_chk(`E1S_ADDR_SSR, exp_ssr(6'd0));
    tpulse(3);
    rd_chk(`E1S_ADDR_SSR, exp_ssr(6'd3));
    pulse(4, 8'h00);
    idle(2);
    rd_chk(`E1S_ADDR_SSR, exp_ssr(6'd0));
    tpulse(4);
    host.write_reg(`E1S_ADDR_CCR1, 8'h00);
    tpulse(2);
    rd_chk(`E1S_ADDR_SSR, exp_ssr(6'd0));
    host.write_reg(`E1S_ADDR_SSR, 8'hff);
    rd_chk(`E1S_ADDR_SSR, 8'h05);
    for (int n = 0; n < 8; n++) begin
      pulse(2, 8'h01 << n);
      poll_chk(`E1S_ADDR_RIR, 8'hff, 8'h01 << n);
      poll_chk(`E1S_ADDR_RIR, 8'hff, 8'h00);
    end
    pulse(2, 8'h81);
    // plain writes here: the write-back of a poll would reload the held bit with zero
    host.write_reg(`E1S_ADDR_RIR, 8'h01);
    rd_chk(`E1S_ADDR_RIR, 8'h01);
    host.write_reg(`E1S_ADDR_RIR, 8'h80);
    rd_chk(`E1S_ADDR_RIR, 8'h81);
    poll_chk(`E1S_ADDR_RIR, 8'hff, 8'h00);
    receive_info_flags <= 8'h10;
    poll_chk(`E1S_ADDR_RIR, 8'h10, 8'h10);
    poll_chk(`E1S_ADDR_RIR, 8'h10, 8'h10);
    receive_info_flags <= 8'h00;
    idle(3);
    poll_chk(`E1S_ADDR_RIR, 8'h10, 8'h10);
    poll_chk(`E1S_ADDR_RIR, 8'h10, 8'h00);
    for (int k = 0; k < 2; k++) begin
      host.write_reg(k ? `E1S_ADDR_IRQ_MASK_TWO : `E1S_ADDR_IRQ_MASK_ONE, 8'h08);
      pulse(k, 8'h04);
      idle(3);
      check({6'h00, irq2, irq1}, 8'h00);
      pulse(k, 8'h08);
      idle(3);
      check({6'h00, irq2, irq1}, k ? 8'h02 : 8'h01);
      poll_chk(k ? `E1S_ADDR_SR2 : `E1S_ADDR_SR1, 8'h08, 8'h08);
      idle(3);
      check({6'h00, irq2, irq1}, 8'h00);
      poll_chk(k ? `E1S_ADDR_SR2 : `E1S_ADDR_SR1, 8'h04, 8'h04);
    end
    host.write_reg(8'h3f, 8'hff);
    rd_chk(8'h3f, 8'h00);
    end_of_test();
  end
endmodule // e1s_status_top_tb_top
`default_nettype wire
